// ==== common/sac_div_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sac_div_if;
  logic [sac_pkg::DIV_W-1:0] div;
  logic                      src_tick;
  logic                      run;
  logic                      sar_tick;

  modport ctrl (output div, output src_tick, output run, input sar_tick);
  modport divider (input div, input src_tick, input run, output sar_tick);
endinterface // sac_div_if
`default_nettype wire

// ==== common/sac_pkg.sv ====
package sac_pkg;

  // converter geometry
  localparam int unsigned RES_W     = 10;
  localparam int unsigned DIV_W     = 5;
  localparam int unsigned BIT_IDX_W = 4;
  localparam int unsigned TRK_W     = 2;

  // register addresses on the special-function register bus
  localparam logic [7:0] ADDR_CFG      = 8'h97;
  localparam logic [7:0] ADDR_RES_HI   = 8'hA1;
  localparam logic [7:0] ADDR_RES_LO   = 8'hA2;
  localparam logic [7:0] ADDR_GT_HI    = 8'hA3;
  localparam logic [7:0] ADDR_GT_LO    = 8'hA4;
  localparam logic [7:0] ADDR_LT_HI    = 8'hA5;
  localparam logic [7:0] ADDR_LT_LO    = 8'hA6;
  localparam logic [7:0] ADDR_STATUS   = 8'hA7;

  // configuration register layout
  localparam logic [7:0] CFG_RESET     = 8'hF8;
  localparam int unsigned CFG_DIV_HI   = 7;
  localparam int unsigned CFG_DIV_LO   = 3;
  localparam int unsigned CFG_EIGHT    = 2;
  localparam int unsigned CFG_TRACK    = 1;
  localparam int unsigned CFG_GAIN     = 0;

  // status register layout
  localparam int unsigned STS_WIN      = 0;
  localparam int unsigned STS_BUSY     = 1;

  // limit and result reset values
  localparam logic [RES_W-1:0] GT_RESET  = 10'h3FF;
  localparam logic [RES_W-1:0] LT_RESET  = 10'h000;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;

  // high byte holds result / limit bits 9:8
  localparam int unsigned HI_BITS      = 2;

  // conversion sequencing
  localparam logic [TRK_W-1:0]     TRACK_DELAY = 2'h3;
  localparam logic [BIT_IDX_W-1:0] MSB_IDX     = 4'h9;
  localparam logic [BIT_IDX_W-1:0] LSB_IDX_10  = 4'h0;
  localparam logic [BIT_IDX_W-1:0] LSB_IDX_8   = 4'h2;

  typedef enum logic [2:0] {
    SAC_IDLE  = 3'b001,
    SAC_TRACK = 3'b010,
    SAC_CONV  = 3'b100
  } sac_state_t;

endpackage : sac_pkg

// ==== core/sac_clkdiv.sv ====
`timescale 1ns/1ps
`default_nettype none
module sac_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  sac_div_if.divider      dif
);

  logic [sac_pkg::DIV_W-1:0] cnt_q;
  logic [sac_pkg::DIV_W-1:0] cnt_d;
  logic                      tick_q;
  logic                      tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!dif.run) begin
      // held in reset between conversions so each period starts aligned
      cnt_d = '0;
    end else if (dif.src_tick) begin
      if (cnt_q >= dif.div) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign dif.sar_tick = tick_q;

endmodule // sac_clkdiv
`default_nettype wire

// ==== core/sac_top.sv ====
// Function
// - conversion clock is source clock divided by divider field plus one.
// - source is system clock, or low-power oscillator when burst mode is on.
// - config bit two set gives eight-bit conversion, clear gives ten-bit.
// - normal track mode starts converting right after start signal.
// - delayed track mode waits three conversion clocks, tracking meanwhile.
// - result is a ten-bit unsigned code from zero to full scale.
// - inside window flags when greater limit < result < less limit.
// - outside window flags when result below lower or above upper bound.
// - configuration resets with divider all ones, other bits clear.
`timescale 1ns/1ps
`default_nettype none
module sac_top (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  output logic      [7:0] SFR_RDATA_O,
  input  wire logic       CONV_ENABLE_I,
  input  wire logic       START_CONV_I,
  input  wire logic       BURST_MODE_ENABLE_I,
  input  wire logic       LP_OSC_TICK_I,
  input  wire logic       COMPARE_I,
  output logic      [9:0] DAC_CODE_O,
  output logic            TRACKING_O,
  output logic            BUSY_O,
  output logic            CONV_DONE_O,
  output logic      [9:0] RESULT_O,
  output logic            WINDOW_COMPARE_FLAG_O,
  output logic            EIGHT_BIT_SELECT_O,
  output logic            PGA_GAIN_SELECT_O
);

  localparam int unsigned RW = sac_pkg::RES_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // register group
  logic [7:0]    cfg_q;
  logic [7:0]    cfg_d;
  logic [RW-1:0] gt_q;
  logic [RW-1:0] gt_d;
  logic [RW-1:0] lt_q;
  logic [RW-1:0] lt_d;
  logic          win_q;
  logic          win_d;
  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;

  // converter group
  sac_pkg::sac_state_t           state_q;
  sac_pkg::sac_state_t           state_d;
  logic [sac_pkg::TRK_W-1:0]     trk_q;
  logic [sac_pkg::TRK_W-1:0]     trk_d;
  logic [sac_pkg::BIT_IDX_W-1:0] idx_q;
  logic [sac_pkg::BIT_IDX_W-1:0] idx_d;
  logic [RW-1:0]                 code_q;
  logic [RW-1:0]                 code_d;
  logic [RW-1:0]                 res_q;
  logic [RW-1:0]                 res_d;
  logic                          done_q;
  logic                          done_d;

  logic                          sar_tick;
  logic                          in_window;
  logic                          eight_bit;
  logic [sac_pkg::BIT_IDX_W-1:0] lsb_idx;
  logic [RW-1:0]                 trial_bit;
  logic [RW-1:0]                 low_bit;

  sac_div_if dif ();

  assign dif.div = cfg_q[sac_pkg::CFG_DIV_HI:sac_pkg::CFG_DIV_LO];
  assign dif.src_tick = BURST_MODE_ENABLE_I ? LP_OSC_TICK_I : 1'b1;
  assign dif.run      = (state_q != sac_pkg::SAC_IDLE);
  assign sar_tick     = dif.sar_tick;

  sac_clkdiv u_div (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .dif     (dif)
  );

  // eight-bit mode stops two bits early
  assign eight_bit = cfg_q[sac_pkg::CFG_EIGHT];
  assign lsb_idx   = eight_bit ? sac_pkg::LSB_IDX_8 : sac_pkg::LSB_IDX_10;

  // one-hot weight of the bit under trial and of the next lower bit
  assign trial_bit = RW'(1) << idx_q;
  assign low_bit   = trial_bit >> 1;

  // inside window when limits are ordered
  // outside window when limits are swapped
  always_comb begin
    if (gt_q < lt_q) begin
      in_window = (res_d > gt_q) && (res_d < lt_q);
    end else begin
      in_window = (res_d < lt_q) || (res_d > gt_q);
    end
  end

  // converter next state
  always_comb begin
    state_d = state_q;
    trk_d   = trk_q;
    idx_d   = idx_q;
    code_d  = code_q;
    res_d   = res_q;
    done_d  = 1'b0;
    unique case (state_q)
      sac_pkg::SAC_IDLE: begin
        // starts while disabled or busy are dropped
        if (CONV_ENABLE_I && START_CONV_I) begin
          trk_d  = '0;
          idx_d  = sac_pkg::MSB_IDX;
          code_d = RW'(1) << sac_pkg::MSB_IDX;
          if (cfg_q[sac_pkg::CFG_TRACK]) begin
            state_d = sac_pkg::SAC_TRACK;
            code_d  = '0;
          end else begin
            state_d = sac_pkg::SAC_CONV;
          end
        end
      end
      sac_pkg::SAC_TRACK: begin
        if (sar_tick) begin
          if (trk_q == sac_pkg::TRACK_DELAY - 1'b1) begin
            state_d = sac_pkg::SAC_CONV;
            code_d  = RW'(1) << sac_pkg::MSB_IDX;
          end else begin
            trk_d = trk_q + 1'b1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        if (sar_tick) begin
          code_d = COMPARE_I ? code_q : (code_q & ~trial_bit);
          if (idx_q == lsb_idx) begin
            state_d = sac_pkg::SAC_IDLE;
            res_d   = code_d;
            done_d  = 1'b1;
            code_d  = '0;
          end else begin
            code_d = code_d | low_bit;
            idx_d  = idx_q - 1'b1;
          end
        end
      end
      default: begin
        state_d = sac_pkg::SAC_IDLE;
        code_d  = '0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q <= sac_pkg::SAC_IDLE;
      trk_q   <= '0;
      idx_q   <= '0;
      code_q  <= '0;
      res_q   <= sac_pkg::RES_RESET;
      done_q  <= 1'b0;
    end else if (CE_I) begin
      state_q <= state_d;
      trk_q   <= trk_d;
      idx_q   <= idx_d;
      code_q  <= code_d;
      res_q   <= res_d;
      done_q  <= done_d;
    end
  end

  // register next state
  always_comb begin
    cfg_d   = cfg_q;
    gt_d    = gt_q;
    lt_d    = lt_q;
    win_d   = win_q;
    rdata_d = rdata_q;
    if (SFR_WR_I) begin
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_CFG)) begin
        cfg_d = SFR_WDATA_I;
      end
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_GT_HI)) begin
        gt_d[RW-1:8] = SFR_WDATA_I[sac_pkg::HI_BITS-1:0];
      end
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_GT_LO)) begin
        gt_d[7:0] = SFR_WDATA_I;
      end
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_LT_HI)) begin
        lt_d[RW-1:8] = SFR_WDATA_I[sac_pkg::HI_BITS-1:0];
      end
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_LT_LO)) begin
        lt_d[7:0] = SFR_WDATA_I;
      end
      if (hit(SFR_ADDR_I, sac_pkg::ADDR_STATUS) &&
          !SFR_WDATA_I[sac_pkg::STS_WIN]) begin
        win_d = 1'b0;
      end
    end
    if (done_d && in_window) begin
      win_d = 1'b1;
    end
    if (SFR_RD_I) begin
      rdata_d = 8'h00;
      unique case (1'b1)
        hit(SFR_ADDR_I, sac_pkg::ADDR_CFG):    rdata_d = cfg_q;
        hit(SFR_ADDR_I, sac_pkg::ADDR_RES_HI):
          rdata_d[sac_pkg::HI_BITS-1:0] = res_q[RW-1:8];
        hit(SFR_ADDR_I, sac_pkg::ADDR_RES_LO): rdata_d = res_q[7:0];
        hit(SFR_ADDR_I, sac_pkg::ADDR_GT_HI):
          rdata_d[sac_pkg::HI_BITS-1:0] = gt_q[RW-1:8];
        hit(SFR_ADDR_I, sac_pkg::ADDR_GT_LO):  rdata_d = gt_q[7:0];
        hit(SFR_ADDR_I, sac_pkg::ADDR_LT_HI):
          rdata_d[sac_pkg::HI_BITS-1:0] = lt_q[RW-1:8];
        hit(SFR_ADDR_I, sac_pkg::ADDR_LT_LO):  rdata_d = lt_q[7:0];
        hit(SFR_ADDR_I, sac_pkg::ADDR_STATUS): begin
          rdata_d[sac_pkg::STS_WIN]  = win_q;
          rdata_d[sac_pkg::STS_BUSY] = (state_q != sac_pkg::SAC_IDLE);
        end
        // unmapped addresses read as zero
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_q   <= sac_pkg::CFG_RESET;
      gt_q    <= sac_pkg::GT_RESET;
      lt_q    <= sac_pkg::LT_RESET;
      win_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else if (CE_I) begin
      cfg_q   <= cfg_d;
      gt_q    <= gt_d;
      lt_q    <= lt_d;
      win_q   <= win_d;
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA_O           = rdata_q;
  assign DAC_CODE_O            = code_q;
  assign TRACKING_O            = (state_q != sac_pkg::SAC_CONV);
  assign BUSY_O                = (state_q != sac_pkg::SAC_IDLE);
  assign CONV_DONE_O           = done_q;
  assign RESULT_O              = res_q;
  assign WINDOW_COMPARE_FLAG_O = win_q;
  assign EIGHT_BIT_SELECT_O    = eight_bit;
  assign PGA_GAIN_SELECT_O     = cfg_q[sac_pkg::CFG_GAIN];

endmodule // sac_top
`default_nettype wire

// ==== testbench/sac_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sac_top_monitor (
  input wire logic       SYS_CLK_I,
  input wire logic       RESET_N_I,
  input wire logic       CE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic       SFR_WR_I,
  input wire logic       SFR_RD_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic       CONV_ENABLE_I,
  input wire logic       START_CONV_I,
  input wire logic [9:0] DAC_CODE_O,
  input wire logic       TRACKING_O,
  input wire logic       BUSY_O,
  input wire logic       CONV_DONE_O,
  input wire logic [9:0] RESULT_O,
  input wire logic       WINDOW_COMPARE_FLAG_O,
  input wire logic       EIGHT_BIT_SELECT_O,
  input wire logic       PGA_GAIN_SELECT_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_trk; (BUSY_O && TRACKING_O) [*3]; endsequence
  sequence s_end; ##[1:1000] CONV_DONE_O; endsequence
  property p_start;
    START_CONV_I && CONV_ENABLE_I && CE_I && !BUSY_O |=> BUSY_O;
  endproperty
  property p_norm; $rose(BUSY_O) && !TRACKING_O |-> DAC_CODE_O == 10'h200;
  endproperty
  property p_trk; $rose(BUSY_O) && TRACKING_O |-> s_trk; endproperty
  property p_dac; TRACKING_O |-> DAC_CODE_O == 10'h000; endproperty
  property p_done; $rose(BUSY_O) |-> s_end; endproperty
  property p_pulse; CONV_DONE_O |-> !BUSY_O ##1 !CONV_DONE_O; endproperty
  property p_res; !$stable(RESULT_O) |-> CONV_DONE_O; endproperty
  property p_eight;
    CONV_DONE_O && EIGHT_BIT_SELECT_O |-> RESULT_O[1:0] == 2'h0;
  endproperty
  property p_cfg;
    SFR_RD_I && CE_I && SFR_ADDR_I == sac_pkg::ADDR_CFG |=>
      SFR_RDATA_O[2] == $past(EIGHT_BIT_SELECT_O) &&
      SFR_RDATA_O[0] == $past(PGA_GAIN_SELECT_O);
  endproperty
  property p_flag;
    WINDOW_COMPARE_FLAG_O &&
      !(SFR_WR_I && CE_I && SFR_ADDR_I == sac_pkg::ADDR_STATUS)
      |=> WINDOW_COMPARE_FLAG_O;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");
  a_norm: assert property (p_norm)
    else $error("first trial wrong");
  a_trk: assert property (p_trk)
    else $error("tracking too short");
  a_dac: assert property (p_dac)
    else $error("dac moved while tracking");
  a_done: assert property (p_done)
    else $error("conversion too long");
  a_pulse: assert property (p_pulse)
    else $error("done pulse wrong");
  a_res: assert property (p_res)
    else $error("result changed without done");
  a_eight: assert property (p_eight)
    else $error("low bits set in eight-bit mode");
  a_cfg: assert property (p_cfg)
    else $error("config read mismatch");
  a_flag: assert property (p_flag)
    else $error("flag dropped without clear");
endmodule // sac_top_monitor
`default_nettype wire

// ==== testbench/tb_sac_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_sac_top;
  logic       clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, en = 1;
  logic       start = 0, burst = 0, lp = 0, cmp = 0, rd_pend = 0;
  logic       trk, busy, done, flag, eight, pga, xflag = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [9:0] dac, res, vin = 10'h000, gt = 10'h3FF, lt = 10'h000;
  logic [7:0] rq[$];
  logic [10:0] cq[$];
  logic [7:0] rexp;
  logic [10:0] cexp;
  int         fails = 0, check_count = 0, seed = 14200, cyc = 0;
  int         n, len, t[6];
  logic [7:0] cfg_tab[6] = '{8'h00, 8'h08, 8'h18, 8'h04, 8'h02, 8'h0B};
  logic [9:0] wv[8] = '{10'h040, 10'h041, 10'h07F, 10'h080,
                        10'h03F, 10'h040, 10'h080, 10'h081};
  always #12.5 clk = ~clk;
  sac_top dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd),
    .SFR_RDATA_O(rdata), .CONV_ENABLE_I(en), .START_CONV_I(start),
    .BURST_MODE_ENABLE_I(burst), .LP_OSC_TICK_I(lp), .COMPARE_I(cmp),
    .DAC_CODE_O(dac), .TRACKING_O(trk), .BUSY_O(busy),
    .CONV_DONE_O(done), .RESULT_O(res), .WINDOW_COMPARE_FLAG_O(flag),
    .EIGHT_BIT_SELECT_O(eight), .PGA_GAIN_SELECT_O(pga));
  // low-power oscillator at half the system rate; comparator follows dac
  always @(posedge clk) begin
    #2;
    lp = ~lp;
    cmp = (vin >= dac);
  end
  always @(posedge clk) begin
    // pop once: the compare macro names its arguments twice
    if (rd_pend) begin
      rexp = rq.pop_front();
      `CHK(rdata, rexp)
    end
    rd_pend = rd & ce;
    if (done === 1'b1) begin
      cexp = cq.pop_front();
      `CHK({flag, res}, cexp)
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic step;
    @(posedge clk);
    #2;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    step; addr = a; wdata = d; wr = 1; step; wr = 0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    step; addr = a; rd = 1; rq.push_back(e); step; rd = 0;
  endtask
  task automatic lim(input logic [9:0] g, input logic [9:0] l);
    gt = g;
    lt = l;
    wr8(sac_pkg::ADDR_GT_HI, {6'h00, g[9:8]});
    wr8(sac_pkg::ADDR_GT_LO, g[7:0]);
    wr8(sac_pkg::ADDR_LT_HI, {6'h00, l[9:8]});
    wr8(sac_pkg::ADDR_LT_LO, l[7:0]);
  endtask
  function automatic logic hit(input logic [9:0] r);
    return (gt < lt) ? (gt < r && r < lt) : (r < lt || r > gt);
  endfunction
  task automatic conv(input logic [9:0] v, input logic clr,
                      input logic eb, output int l);
    logic [9:0] r;
    if (clr) wr8(sac_pkg::ADDR_STATUS, 8'h00);
    if (clr) xflag = 0;
    r = eb ? (v & 10'h3FC) : v;
    xflag = xflag | hit(r);
    cq.push_back({xflag, r});
    step; vin = v; start = 1; step; start = 0;
    l = 0;
    while (busy !== 1'b0 && l < 2000) begin step; l++; end
    step;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #2 rst_n = 1;
    rd8(sac_pkg::ADDR_CFG, sac_pkg::CFG_RESET);
    rd8(8'hFF, 8'h00);
    `CHK({eight, pga}, 2'h0)
    $display("test reset done");
    for (n = 0; n < 6; n++) begin
      wr8(sac_pkg::ADDR_CFG, cfg_tab[n]);
      rd8(sac_pkg::ADDR_CFG, cfg_tab[n]);
      `CHK({eight, pga}, {cfg_tab[n][2], cfg_tab[n][0]})
      conv(10'($random(seed)), 1, cfg_tab[n][2], t[n]);
    end
    // busy time against divider period, eight-bit mode and delayed track mode
    `CHK(t[1] - t[0], 10)
    `CHK(t[2] - t[1], 20)
    `CHK(t[0] - t[3], 2)
    `CHK(t[4] - t[0], 3)
    `CHK(t[5] - t[1], 6)
    $display("test modes done");
    wr8(sac_pkg::ADDR_CFG, 8'h00);
    for (n = 0; n < 8; n++) begin
      if (n == 0) lim(10'h040, 10'h080);
      if (n == 4) lim(10'h080, 10'h040);
      conv(wv[n], 1, 0, len);
    end
    conv(10'h060, 0, 0, len);
    // writing one to the flag bit must leave it set
    wr8(sac_pkg::ADDR_STATUS, 8'h01);
    rd8(sac_pkg::ADDR_STATUS, 8'h01);
    rd8(sac_pkg::ADDR_RES_LO, 8'h60);
    rd8(sac_pkg::ADDR_GT_LO, 8'h80);
    rd8(sac_pkg::ADDR_LT_LO, 8'h40);
    wr8(sac_pkg::ADDR_STATUS, 8'h00);
    rd8(sac_pkg::ADDR_STATUS, 8'h00);
    $display("test window done");
    burst = 1;
    conv(10'($random(seed)), 1, 0, len);
    // oscillator ticks every other cycle, phase unknown
    `CHK(len == 20 || len == 21, 1'b1)
    burst = 0;
    $display("test burst done");
    en = 0;
    step; start = 1; step; start = 0; step;
    `CHK(busy, 1'b0)
    en = 1;
    ce = 0;
    wr8(sac_pkg::ADDR_CFG, 8'h55);
    ce = 1;
    rd8(sac_pkg::ADDR_CFG, 8'h00);
    step;
    $display("test refuse done");
    end_of_test();
  end
endmodule // tb_sac_top
bind sac_top sac_top_monitor u_mon (.*);
`default_nettype wire
